// ===== prs_route_lock.sv
// pin route select registers, keyed lock and the routing itself
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps

// What this block and the software using it must do
// R1 - lock state changes only after writes of 0x55 then 0xAA to the lock register
// R2 - one-way config set: lock can be set once, clearing ignored until reset
// R3 - one-way config clear: lock set and cleared freely, each needs the key pair
// R4 - while locked, writes to every selection register are ignored
// R5 - while unlocked, selection registers take software writes
// R6 - sleep entry and exit leave all selections as they are
// R7 - power-on/brown-out reset loads input defaults and zeroes output sources
// R8 - other resets leave every selection register unchanged
// R9 - every reset clears the locked flag
// R10 - input select bits 5:3 choose port A, B or C
// R11 - input select bits 2:0 choose pin 0 to 7 of that port
// R12 - each input select resets to its own peripheral default pin
// R13 - output select bits 5:0 hold source code, reset to zero
// R14 - locked flag is bit 0 of lock register, other bits read zero
// R15 - software disables interrupts around the key sequence
// R16 - pin direction control keeps governing the driver except for owning peripherals
// R17 - bidirectional peripherals need input and output routed to one pin
// R18 - any other access between key writes aborts the key sequence
module prs_route_lock (
	// clock and resets
	input  wire logic                                clock,
	input  wire logic                                rst_n,
	input  wire logic                                clock_en,
	input  wire logic                                other_reset,
	// configuration
	input  wire logic                                one_shot_lock_config,
	// register bus
	input  wire logic [prs_pkg::AW-1:0]              address,
	input  wire logic                                read,
	input  wire logic                                write,
	input  wire logic [31:0]                         writedata,
	input  wire logic [3:0]                          byteenable,
	output logic      [31:0]                         readdata,
	output logic      [1:0]                          response,
	output logic                                     waitrequest,
	// device pins
	input  wire logic [prs_pkg::N_PIN-1:0]           pin_in,
	output logic      [prs_pkg::N_PIN-1:0]           pin_out,
	output logic      [prs_pkg::N_PIN-1:0]           pin_oe,
	// port latch and direction
	input  wire logic [prs_pkg::N_PIN-1:0]           latch_data,
	input  wire logic [prs_pkg::N_PIN-1:0]           pin_direction_control,
	// peripheral side
	input  wire logic [prs_pkg::N_SRC-1:1]           periph_out,
	input  wire logic [prs_pkg::N_SRC-1:1]           periph_drv_own,
	input  wire logic [prs_pkg::N_SRC-1:1]           periph_drv_oe,
	output logic      [prs_pkg::N_IN-1:0]            periph_in,
	// state seen by the rest of the device
	output logic                                     route_locked_flag,
	output prs_pkg::prs_in_sel_t [prs_pkg::N_IN-1:0] in_sel,
	output logic [prs_pkg::N_PIN-1:0][5:0]           out_src
);
	import prs_pkg::*;

	////////////////////////////////////////////////////////////////
	// decoding
	function automatic prs_dec_t decode(input logic [AW-1:0] a);
		prs_dec_t    d;
		logic [12:0] w;
		d.kind = DK_NONE;
		d.idx = 5'h00;
		w = a[14:2];
		if (a[15] || (a[1:0] != 2'h0)) begin
			d.kind = DK_NONE;
		end else if (w == OFS_LOCK) begin
			d.kind = DK_LOCK;
		end else if ((w >= OFS_OUT0) && (w < OFS_OUT0 + 13'(N_PIN))) begin
			d.kind = DK_OUT;
			d.idx = 5'(w - OFS_OUT0);
		end else begin
			for (int i = 0; i < N_IN; i++) begin
				if (w == OFS_IN[i]) begin
					d.kind = DK_IN;
					d.idx = 5'(i);
				end
			end
		end
		return d;
	endfunction : decode

	// value driven onto one pin by its source code
	function automatic logic pick_src(
		input logic [5:0]       code,
		input logic             lat,
		input logic [N_SRC-1:1] po
	);
		logic v;
		v = 1'b0;
		if (code == SRC_LAT) begin
			v = lat;
		end else if (code < 6'(N_SRC)) begin
			v = po[code];
		end
		return v;
	endfunction : pick_src

	// driver enable: direction control unless the source owns the driver
	function automatic logic pick_oe(
		input logic [5:0]       code,
		input logic             dir_in,
		input logic [N_SRC-1:1] own,
		input logic [N_SRC-1:1] oe
	);
		logic v;
		v = !dir_in;
		if ((code != SRC_LAT) && (code < 6'(N_SRC))) begin
			if (own[code]) begin
				v = oe[code];
			end
		end
		return v;
	endfunction : pick_oe

	////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, then the access completes
	prs_dec_t    dec;
	logic        ack;
	logic        req;
	logic        acc_wr;
	logic        acc_any;
	logic        sel_wr;
	logic        lock_wr;
	logic [31:0] rd_val;
	prs_key_t    key_state;
	prs_key_t    next_key_state;

	assign dec = decode(address);
	assign req = read | write;
	assign waitrequest = req & !(ack & clock_en);
	assign acc_any = req & ack & clock_en;
	assign acc_wr = write & ack & clock_en;
	// narrow data lives in byte lane 0
	assign lock_wr = acc_wr & byteenable[0] & (dec.kind == DK_LOCK);
	assign sel_wr = acc_wr & byteenable[0] & !route_locked_flag; // R4 R5

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack <= 1'b0;
		end else if (clock_en) begin
			ack <= req & !ack;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		if (dec.kind == DK_LOCK) begin
			rd_val[LOCK_BIT] = route_locked_flag; // R14
		end else if (dec.kind == DK_IN) begin
			rd_val[5:0] = in_sel[dec.idx]; // R10 R11
		end else if (dec.kind == DK_OUT) begin
			rd_val[5:0] = out_src[dec.idx]; // R13
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			readdata <= 32'h0000_0000;
			response <= RESP_OK;
		end else if (clock_en && req && !ack) begin
			readdata <= read ? rd_val : 32'h0000_0000;
			response <= (dec.kind == DK_NONE) ? RESP_ERR : RESP_OK;
		end
	end

	////////////////////////////////////////////////////////////////
	// key sequence
	always_comb begin
		next_key_state = KS_IDLE;
		case (key_state)
			KS_IDLE: begin
				if (lock_wr && (writedata[7:0] == KEY_FIRST)) begin // R1
					next_key_state = KS_GOT_FIRST;
				end
			end
			KS_GOT_FIRST: begin
				next_key_state = KS_GOT_FIRST;
				if (acc_any) begin
					next_key_state = KS_IDLE; // R18
					if (lock_wr && (writedata[7:0] == KEY_SECOND)) begin // R1
						next_key_state = KS_ARMED;
					end
				end
			end
			KS_ARMED: begin
				next_key_state = KS_ARMED;
				if (acc_any) begin
					next_key_state = KS_IDLE; // R18
				end
			end
			default: begin
				next_key_state = KS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n || other_reset) begin
			key_state <= KS_IDLE;
		end else if (clock_en) begin
			key_state <= next_key_state;
		end
	end

	////////////////////////////////////////////////////////////////
	// locked flag
	always_ff @(posedge clock) begin
		if (!rst_n || other_reset) begin
			route_locked_flag <= 1'b0; // R9
		end else if (clock_en && lock_wr && (key_state == KS_ARMED)) begin
			if (writedata[LOCK_BIT]) begin
				route_locked_flag <= 1'b1; // R1
			end else if (!one_shot_lock_config) begin
				route_locked_flag <= 1'b0; // R3
			end
			// one-way: clearing ignored until the next reset R2
		end
	end

	////////////////////////////////////////////////////////////////
	// selection registers
	// no sleep term anywhere: selections only move on writes and power-on reset R6
	// other_reset is deliberately absent here R8
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int i = 0; i < N_IN; i++) begin
				in_sel[i] <= IN_RST[i]; // R7 R12
			end
		end else if (sel_wr && (dec.kind == DK_IN)) begin
			in_sel[dec.idx] <= writedata[5:0]; // R10 R11
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int j = 0; j < N_PIN; j++) begin
				out_src[j] <= OUT_RST; // R7 R13
			end
		end else if (sel_wr && (dec.kind == DK_OUT)) begin
			out_src[dec.idx] <= writedata[5:0]; // R13
		end
	end

	////////////////////////////////////////////////////////////////
	// pin input synchroniser, change taken once stages two and three agree
	logic [N_PIN-1:0] pin_s1;
	logic [N_PIN-1:0] pin_s2;
	logic [N_PIN-1:0] pin_s3;
	logic [N_PIN-1:0] pin_filt;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_filt <= '0;
		end else if (clock_en) begin
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			for (int j = 0; j < N_PIN; j++) begin
				if (pin_s2[j] == pin_s3[j]) begin
					pin_filt[j] <= pin_s3[j];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// input routing: port codes above C select nothing
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			periph_in <= '0;
		end else if (clock_en) begin
			for (int i = 0; i < N_IN; i++) begin
				if (in_sel[i].port <= PORT_LAST) begin
					periph_in[i] <= pin_filt[{in_sel[i].port[1:0], in_sel[i].pin}]; // R10 R11
				end else begin
					periph_in[i] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// output routing, registered to keep pin glitches off
	genvar gj;
	generate
		for (gj = 0; gj < N_PIN; gj++) begin : g_pin
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					pin_out[gj] <= 1'b0;
					pin_oe[gj] <= 1'b0;
				end else if (clock_en) begin
					pin_out[gj] <= pick_src(out_src[gj], latch_data[gj], periph_out); // R13
					pin_oe[gj] <= pick_oe(out_src[gj], pin_direction_control[gj],
						periph_drv_own, periph_drv_oe); // R16
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_key_first;
		lock_wr && (writedata[7:0] == KEY_FIRST) && (key_state == KS_IDLE);
	endsequence

	sequence s_armed_lock_wr;
		lock_wr && (key_state == KS_ARMED) && !other_reset;
	endsequence

	a_key_before_lock: assert property ( // R1
		$rose(route_locked_flag) |-> $past(key_state) == KS_ARMED && $past(lock_wr)
	) else $error("lock set without key pair");

	a_key_first_step: assert property ( // R1
		s_key_first and !other_reset |=> key_state == KS_GOT_FIRST
	) else $error("first key not taken");

	a_oneway_holds: assert property ( // R2
		one_shot_lock_config && route_locked_flag && !other_reset
			|=> route_locked_flag
	) else $error("one-way lock was cleared");

	a_free_clear: assert property ( // R3
		s_armed_lock_wr and !one_shot_lock_config && !writedata[LOCK_BIT]
			|=> !route_locked_flag
	) else $error("keyed clear not applied");

	a_locked_frozen: assert property ( // R4
		route_locked_flag && acc_wr && (dec.kind inside {DK_IN, DK_OUT})
			|=> $stable(in_sel) && $stable(out_src)
	) else $error("selection changed while locked");

	a_unlocked_write: assert property ( // R5
		!route_locked_flag && acc_wr && byteenable[0] && (dec.kind == DK_IN)
			|=> in_sel[$past(dec.idx)] == $past(writedata[5:0])
	) else $error("unlocked write not stored");

	a_por_defaults: assert property (disable iff (1'b0) // R7
		!rst_n |=> in_sel[0] == IN_RST[0] && in_sel[N_IN-1] == IN_RST[N_IN-1]
			&& out_src == '0 && !route_locked_flag
	) else $error("power-on defaults wrong");

	a_other_keeps: assert property ( // R8
		other_reset && !acc_wr |=> $stable(in_sel) && $stable(out_src)
			&& !route_locked_flag && key_state == KS_IDLE
	) else $error("other reset touched selections");

	a_abort_seq: assert property ( // R18
		key_state == KS_GOT_FIRST && acc_any && !lock_wr |=> key_state == KS_IDLE
	) else $error("stray access did not abort keys");

	a_dir_governs: assert property ( // R16
		clock_en && out_src[0] == SRC_LAT |=> pin_oe[0] == !$past(pin_direction_control[0])
	) else $error("direction control lost");

	a_owner_drives: assert property ( // R16
		clock_en && (out_src[10] == 6'h02) && periph_drv_own[2]
			|=> pin_oe[10] == $past(periph_drv_oe[2])
	) else $error("owning peripheral lost its driver");

	a_one_wait: assert property (
		clock_en && req && !ack ##1 clock_en && req |-> !waitrequest
	) else $error("answer not after one wait cycle");

endmodule : prs_route_lock

// ===== prs_pkg.sv
// constants and types for the pin route select block
package prs_pkg;

	////////////////////////////////////////////////////////////////
	// sizes
	localparam int N_IN  = 13;
	localparam int N_PIN = 24;
	localparam int N_SRC = 10;
	localparam int AW    = 16;

	////////////////////////////////////////////////////////////////
	// register indices (byte address is four times these)
	localparam logic [12:0] OFS_LOCK = 13'h1E8F;
	localparam logic [12:0] OFS_OUT0 = 13'h1F10;
	localparam logic [12:0] OFS_IN [N_IN] = '{
		13'h1E90, 13'h1E91, 13'h1E92, 13'h1E93, 13'h1E9C,
		13'h1EA1, 13'h1EA2, 13'h1EC3, 13'h1EC5, 13'h1EC6,
		13'h1EC7, 13'h1ECB, 13'h1ECC
	};

	////////////////////////////////////////////////////////////////
	// values after power-on reset, port in [5:3], pin in [2:0]
	localparam logic [5:0] IN_RST [N_IN] = '{
		6'h08, 6'h04, 6'h10, 6'h0D, 6'h13,
		6'h12, 6'h11, 6'h0C, 6'h13, 6'h14,
		6'h05, 6'h17, 6'h16
	};
	localparam logic [5:0] OUT_RST = 6'h00;

	////////////////////////////////////////////////////////////////
	// keys, codes, answers
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam int         LOCK_BIT   = 0;
	localparam logic [2:0] PORT_LAST  = 3'h2;
	localparam logic [5:0] SRC_LAT    = 6'h00;
	localparam logic [1:0] RESP_OK    = 2'h0;
	localparam logic [1:0] RESP_ERR   = 2'h2;

	////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		KS_IDLE      = 2'b00,
		KS_GOT_FIRST = 2'b01,
		KS_ARMED     = 2'b10
	} prs_key_t;

	typedef enum logic [1:0] {
		DK_NONE = 2'b00,
		DK_LOCK = 2'b01,
		DK_IN   = 2'b10,
		DK_OUT  = 2'b11
	} prs_kind_t;

	typedef struct packed {
		prs_kind_t  kind;
		logic [4:0] idx;
	} prs_dec_t;

	typedef struct packed {
		logic [2:0] port;
		logic [2:0] pin;
	} prs_in_sel_t;

endpackage : prs_pkg

// ===== prs_far_model.sv
// far-side model: peripheral outputs and external pin sources
`timescale 1ns/1ps
module prs_far_model
	import prs_pkg::*;
(
	// pins
	input  wire logic [N_PIN-1:0] pin_out,
	input  wire logic [N_PIN-1:0] pin_oe,
	input  wire logic [N_PIN-1:0] ext_drive,
	output logic      [N_PIN-1:0] pin_in,
	// peripherals
	output logic      [N_SRC-1:1] periph_out,
	output logic      [N_SRC-1:1] periph_drv_own,
	output logic      [N_SRC-1:1] periph_drv_oe
);
	////////////////////////////////////////////////////////////////
	// a driven pin reads its own level, an undriven one the outside world
	assign pin_in         = (pin_oe & pin_out) | (~pin_oe & ext_drive);
	// odd codes high, so a wrong code shows up as a wrong level
	assign periph_out     = 9'h155;
	// only source code 2 takes the driver and enables it, the rest leave it to direction control
	assign periph_drv_own = 9'h002;
	assign periph_drv_oe  = 9'h002;
endmodule : prs_far_model

// ===== testbench.sv
// self-checking testbench for the pin route select block
`timescale 1ns/1ps
module testbench;
	import prs_pkg::*;
	logic                        clock, rst_n, clock_en, other_reset, one_shot_lock_config;
	logic [AW-1:0]               address;
	logic                        read, write, waitrequest;
	logic [31:0]                 writedata, readdata;
	logic [3:0]                  byteenable;
	logic [1:0]                  response;
	logic [N_PIN-1:0]            pin_in, pin_out, pin_oe, latch_data, pin_direction_control;
	logic [N_PIN-1:0]            ext_drive;
	logic [N_SRC-1:1]            periph_out, periph_drv_own, periph_drv_oe;
	logic [N_IN-1:0]             periph_in;
	logic                        route_locked_flag;
	prs_in_sel_t [N_IN-1:0]      in_sel;
	logic [N_PIN-1:0][5:0]       out_src;
	int                          err_count, comparisons;
	logic [31:0]                 rd;
	logic [1:0]                  rs;

	prs_route_lock uut (.clock, .rst_n, .clock_en, .other_reset, .one_shot_lock_config,
		.address, .read, .write, .writedata, .byteenable, .readdata, .response, .waitrequest,
		.pin_in, .pin_out, .pin_oe, .latch_data, .pin_direction_control, .periph_out,
		.periph_drv_own, .periph_drv_oe, .periph_in, .route_locked_flag, .in_sel, .out_src);
	prs_far_model far (.pin_out, .pin_oe, .ext_drive, .pin_in, .periph_out, .periph_drv_own,
		.periph_drv_oe);

	////////////////////////////////////////////////////////////////
	always #12.5 clock = ~clock;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// one transfer, held until waitrequest is seen low at an edge
	task automatic bus(input logic we, input logic [15:0] a, input logic [7:0] d);
		address   <= a;
		writedata <= {24'h0, d};
		read      <= !we;
		write     <= we;
		do @(posedge clock); while (waitrequest !== 1'b0);
		rd = readdata;
		rs = response;
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic wr(input logic [12:0] idx, input logic [7:0] d);
		bus(1'b1, {1'b0, idx, 2'b00}, d);
	endtask : wr

	task automatic rd_chk(input logic [12:0] idx, input logic [7:0] exp);
		bus(1'b0, {1'b0, idx, 2'b00}, 8'h00);
		check(rd, {24'h0, exp});
		check({30'h0, rs}, {30'h0, RESP_OK});
	endtask : rd_chk

	// interrupts are never modelled here, so nothing splits the keys
	task automatic key(input logic [7:0] v);
		wr(OFS_LOCK, KEY_FIRST);
		wr(OFS_LOCK, KEY_SECOND);
		wr(OFS_LOCK, v);
	endtask : key

	task automatic por();
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
	endtask : por

	task automatic finish_test();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < N_IN; i++) rd_chk(OFS_IN[i], {2'b00, IN_RST[i]});
		rd_chk(OFS_LOCK, 8'h00);
		rd_chk(OFS_OUT0 + 13'h8, 8'h00);
	endtask : t_reset

	task automatic t_fields();
		for (int p = 0; p < 3; p++)
			for (int n = 0; n < 8; n++) begin
				wr(OFS_IN[2], {2'b11, p[2:0], n[2:0]});
				rd_chk(OFS_IN[2], {2'b00, p[2:0], n[2:0]});
			end
		wr(OFS_OUT0 + 13'h8, 8'hFF);
		rd_chk(OFS_OUT0 + 13'h8, 8'h3F);
		bus(1'b0, 16'h8000, 8'h00);
		check({30'h0, rs}, {30'h0, RESP_ERR});
		check(rd, 32'h0);
	endtask : t_fields

	task automatic t_lock();
		key(8'h01);
		rd_chk(OFS_LOCK, 8'h01);
		wr(OFS_IN[1], 8'h3F);
		rd_chk(OFS_IN[1], {2'b00, IN_RST[1]});
		key(8'h00);
		rd_chk(OFS_LOCK, 8'h00);
		wr(OFS_LOCK, 8'h01);
		rd_chk(OFS_LOCK, 8'h00);
		wr(OFS_LOCK, KEY_FIRST);
		rd_chk(OFS_LOCK, 8'h00);
		wr(OFS_LOCK, KEY_SECOND);
		wr(OFS_LOCK, 8'h01);
		rd_chk(OFS_LOCK, 8'h00);
	endtask : t_lock

	task automatic t_one_way();
		one_shot_lock_config <= 1'b1;
		wr(OFS_IN[3], 8'h01);
		key(8'h01);
		key(8'h00);
		rd_chk(OFS_LOCK, 8'h01);
		check({31'h0, route_locked_flag}, 32'h1);
		other_reset <= 1'b1;
		@(posedge clock);
		other_reset <= 1'b0;
		@(posedge clock);
		rd_chk(OFS_LOCK, 8'h00);
		rd_chk(OFS_IN[3], 8'h01);
		rd_chk(OFS_OUT0 + 13'h8, 8'h3F);
		key(8'h01);
		por();
		rd_chk(OFS_LOCK, 8'h00);
		rd_chk(OFS_IN[3], {2'b00, IN_RST[3]});
		rd_chk(OFS_OUT0 + 13'h8, 8'h00);
		one_shot_lock_config <= 1'b0;
	endtask : t_one_way

	task automatic t_route();
		logic [5:0] keep;
		// pins read as inputs so the outside level reaches the router, pin 9 stays an output
		pin_direction_control <= 24'hFFFDFF;
		ext_drive <= 24'h000100;
		repeat (6) @(posedge clock);
		check({31'h0, periph_in[0]}, 32'h1);
		wr(OFS_IN[0], 8'h15);
		ext_drive <= 24'h200000;
		repeat (6) @(posedge clock);
		check({31'h0, periph_in[0]}, 32'h1);
		ext_drive <= 24'h000100;
		repeat (6) @(posedge clock);
		check({31'h0, periph_in[0]}, 32'h0);
		wr(OFS_OUT0 + 13'h9, 8'h01);
		repeat (3) @(posedge clock);
		check({30'h0, pin_oe[9], pin_out[9]}, 32'h3);
		pin_direction_control <= 24'hFFFFFF;
		repeat (3) @(posedge clock);
		check({31'h0, pin_oe[9]}, 32'h0);
		// source 2 owns its driver, so the input direction is overridden
		wr(OFS_OUT0 + 13'hA, 8'h02);
		repeat (3) @(posedge clock);
		check({30'h0, pin_oe[10], pin_out[10]}, 32'h2);
		keep = in_sel[0];
		clock_en <= 1'b0;
		repeat (8) @(posedge clock);
		clock_en <= 1'b1;
		@(posedge clock);
		check({26'h0, in_sel[0]}, {26'h0, keep});
	endtask : t_route

	////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		clock_en = 1'b1;
		other_reset = 1'b0;
		one_shot_lock_config = 1'b0;
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = 4'hF;
		latch_data = 24'hFFFDFF;
		pin_direction_control = 24'h000000;
		ext_drive = 24'h000000;
		err_count = 0;
		comparisons = 0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		t_reset();
		t_fields();
		t_lock();
		t_one_way();
		t_route();
		finish_test();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		finish_test();
	end
endmodule : testbench
